// *** rtl/char_lcd_pkg.sv ***
// Constants shared by the character display host interface
// Operation
// - Two link-select straps pick parallel bus, I2C or 4-line SPI.
// - Nibble mode uses lines 4-7, upper four bits first, then lower.
// - In nibble mode busy rises only after the second nibble.
// - Byte-wide mode moves a whole byte at once on all eight lines.
// - Busy reads high on line 7; host waits for it to clear.
// - Received words go to instruction or data holding register by select.
// - RAM address steps by one, up or down, after each RAM access.
// - SPI: line 5 chip select, line 7 data, clock on serial_clk; select marks byte.
// - SPI clock idles high; data is sampled on the rising edge.
// - One I2C bit per SCL pulse; SDA change while SCL high is control.
// - START is SDA falling with SCL high; STOP is SDA rising.
// - Addressed receiver holds SDA low through the ninth clock high phase.
// - Slave address 0111100 to 0111111, low bits from two address straps.
// - Address mismatch: ignore rest of transfer, give no acknowledge.
// - Control byte then data byte; cleared continuation means data until STOP.
// - Data-select 1 stores to display RAM and steps pointer; 0 is instruction.
// - Busy held high through power-on init, which fills RAM with 20H.
// - Init leaves byte-wide, one line, 5x8, all off, increment, no shift.
// - Data-length bit high selects byte-wide, low selects nibble transfers.
// - Parallel read with select low returns busy on bit 7, counter below.
package char_lcd_pkg;
  localparam int CLK_NS = 40;
  localparam int EXEC_NS = 40000;
  localparam int EXEC_CYC = (EXEC_NS + CLK_NS - 1) / CLK_NS;
  localparam int RAM_DEPTH_DEF = 80;
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [4:0] I2C_ADDR_HI = 5'h0F;
  // Pin positions on the data lines
  localparam int PIN_CS = 5;
  localparam int PIN_SID = 7;
  localparam int PIN_SDA = 6;
  localparam int PIN_SCL = 7;
  localparam int PIN_SA0 = 0;
  localparam int PIN_SA1 = 1;
  // Field positions
  localparam int CTRL_CO = 7;
  localparam int CTRL_A0 = 6;
  localparam int FS_DL = 4;
  localparam int FS_N = 3;
  localparam int FS_F = 2;
  localparam int DC_D = 2;
  localparam int DC_C = 1;
  localparam int DC_B = 0;
  localparam int EM_ID = 1;
  localparam int EM_S = 0;
  localparam int SH_SC = 3;
  localparam int SH_RL = 2;
  typedef enum logic [2:0] {
    LINK_PAR = 3'b001,
    LINK_I2C = 3'b010,
    LINK_SPI = 3'b100
  } link_t;
  typedef enum logic [3:0] {
    I_IDLE = 4'b0001,
    I_RECV = 4'b0010,
    I_ACK = 4'b0100,
    I_SKIP = 4'b1000
  } i2c_st_t;
endpackage

// *** rtl/char_lcd_host_interface.sv ***
// Host-side front end of a character display controller
`timescale 1ns/1ns
`default_nettype none
module char_lcd_host_interface
  import char_lcd_pkg::*;
#(
  parameter int RAM_DEPTH = RAM_DEPTH_DEF,
  parameter int BUSY_CYC = EXEC_CYC
) (
  // Clocks and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic serial_clk,
  // Straps
  input wire logic link_select_strap_hi,
  input wire logic link_select_strap_lo,
  // Parallel bus control
  input wire logic enable_strobe,
  input wire logic register_select,
  input wire logic read_not_write,
  // Data lines
  input wire logic [7:0] db_in,
  output logic [7:0] db_out,
  output logic [7:0] db_oe,
  // Display RAM port
  output logic ram_we,
  output logic [6:0] ram_addr,
  output logic [7:0] ram_wdata,
  input wire logic [7:0] ram_rdata,
  // Received words
  output logic instr_valid,
  output logic [7:0] instruction_holding_reg,
  output logic [7:0] data_holding_reg,
  // Settings and status
  output logic data_length_bit,
  output logic two_line,
  output logic font_tall,
  output logic display_on,
  output logic cursor_on,
  output logic blink_on,
  output logic addr_increment,
  output logic display_shift,
  output logic busy_indication,
  output logic [6:0] address_counter
);
  localparam int BW = $clog2(BUSY_CYC + 1);

  if (RAM_DEPTH < 1 || RAM_DEPTH > 128 || BUSY_CYC < 1) begin : g_bad
    $error("RAM_DEPTH must be 1..128 and BUSY_CYC at least 1");
  end

  // ----------------------------------------------------------------
  // Synchronisers and link selection
  // ----------------------------------------------------------------
  logic [7:0] db_s1_r, db_s2_r, db_q_r;
  logic e_s1_r, e_s2_r, e_q_r, rw_s1_r, rw_s2_r, rs_s1_r, rs_s2_r;
  logic sh_s1_r, sh_s2_r, sl_s1_r, sl_s2_r;
  link_t link_r;

  always_ff @(posedge core_clk) begin
    db_s1_r <= db_in;
    db_s2_r <= db_s1_r;
    db_q_r <= db_s2_r;
    e_s1_r <= enable_strobe;
    e_s2_r <= e_s1_r;
    e_q_r <= e_s2_r;
    rw_s1_r <= read_not_write;
    rw_s2_r <= rw_s1_r;
    rs_s1_r <= register_select;
    rs_s2_r <= rs_s1_r;
    sh_s1_r <= link_select_strap_hi;
    sh_s2_r <= sh_s1_r;
    sl_s1_r <= link_select_strap_lo;
    sl_s2_r <= sl_s1_r;
  end

  // Straps are caught while reset is held and frozen after it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      if (sh_s2_r && !sl_s2_r) link_r <= LINK_SPI;
      else if (!sh_s2_r && sl_s2_r) link_r <= LINK_I2C;
      else link_r <= LINK_PAR;
    end
  end

  // ----------------------------------------------------------------
  // Parallel bus
  // ----------------------------------------------------------------
  logic nib_r;
  logic [3:0] hi_r;
  logic [7:0] rdata_r;
  logic [7:0] rd_word;
  logic e_fall, par_wr, par_rd, par_ev, rd_done, rd_oe;

  assign e_fall = (link_r == LINK_PAR) && e_q_r && !e_s2_r;
  assign par_wr = e_fall && !rw_s2_r;
  assign par_rd = e_fall && rw_s2_r;
  assign par_ev = par_wr && (data_length_bit || nib_r);
  assign rd_done = par_rd && (data_length_bit || nib_r);
  assign rd_oe = (link_r == LINK_PAR) && e_s2_r && rw_s2_r;
  assign rd_word = rs_s2_r ? rdata_r : {busy_indication, address_counter};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      nib_r <= 1'b0;
      hi_r <= 4'h0;
    end else if (e_fall) begin
      nib_r <= data_length_bit ? 1'b0 : ~nib_r;
      if (!rw_s2_r && !data_length_bit && !nib_r) hi_r <= db_s2_r[7:4];
    end
  end

  // Read data: whole byte, or upper then lower nibble on lines 4-7
  logic [7:0] dout_r;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dout_r <= 8'h00;
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= ram_rdata;
      if (!rd_oe) dout_r <= 8'h00;
      else if (data_length_bit) dout_r <= rd_word;
      else if (nib_r) dout_r <= {rd_word[3:0], 4'h0};
      else dout_r <= {rd_word[7:4], 4'h0};
    end
  end

  // ----------------------------------------------------------------
  // 4-line SPI, in the serial clock domain
  // ----------------------------------------------------------------
  logic lrst_s1_r, lrst_s2_r;
  logic [2:0] sbit_r;
  logic [6:0] sshift_r;
  logic [7:0] sbyte_r;
  logic srs_r, stog_r;

  always_ff @(posedge serial_clk) begin
    lrst_s1_r <= rst_n;
    lrst_s2_r <= lrst_s1_r;
  end

  // Sampling on the rising edge of a clock that idles high
  always_ff @(posedge serial_clk) begin
    if (!lrst_s2_r) begin
      sbit_r <= 3'h0;
      stog_r <= 1'b0;
      sshift_r <= 7'h00;
      sbyte_r <= 8'h00;
      srs_r <= 1'b0;
    end else if (db_in[PIN_CS]) begin
      sbit_r <= 3'h0;
    end else begin
      sshift_r <= {sshift_r[5:0], db_in[PIN_SID]};
      sbit_r <= sbit_r + 3'h1;
      if (sbit_r == 3'h7) begin
        sbyte_r <= {sshift_r, db_in[PIN_SID]};
        srs_r <= register_select;
        stog_r <= ~stog_r;
      end
    end
  end

  // Toggle crossing; the byte is stable for a whole byte time after it
  logic st_s1_r, st_s2_r, st_q_r, spi_ev;
  always_ff @(posedge core_clk) begin
    st_s1_r <= stog_r;
    st_s2_r <= st_s1_r;
    st_q_r <= st_s2_r;
  end
  assign spi_ev = (link_r == LINK_SPI) && (st_s2_r ^ st_q_r);

  // ----------------------------------------------------------------
  // I2C slave receiver
  // ----------------------------------------------------------------
  i2c_st_t ist_r;
  logic [3:0] bcnt_r;
  logic [7:0] ishift_r;
  logic addr_ph_r, ctrl_ph_r, co_r, a0_r;
  logic scl, sda, scl_q, sda_q, start, stop, scl_rise, scl_fall;
  logic byte_end, match, i2c_ev;

  assign scl = db_s2_r[PIN_SCL];
  assign sda = db_s2_r[PIN_SDA];
  assign scl_q = db_q_r[PIN_SCL];
  assign sda_q = db_q_r[PIN_SDA];
  assign start = (link_r == LINK_I2C) && scl_q && scl && sda_q && !sda;
  assign stop = (link_r == LINK_I2C) && scl_q && scl && !sda_q && sda;
  assign scl_rise = !scl_q && scl;
  assign scl_fall = scl_q && !scl;
  assign byte_end = (ist_r == I_RECV) && scl_fall && (bcnt_r == 4'h8);
  assign match = (ishift_r[7:1] == {I2C_ADDR_HI, db_s2_r[PIN_SA1], db_s2_r[PIN_SA0]})
    && !ishift_r[0];
  assign i2c_ev = byte_end && !addr_ph_r && !ctrl_ph_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n || link_r != LINK_I2C) begin
      ist_r <= I_IDLE;
      bcnt_r <= 4'h0;
      ishift_r <= 8'h00;
      addr_ph_r <= 1'b1;
      ctrl_ph_r <= 1'b1;
      co_r <= 1'b0;
      a0_r <= 1'b0;
    end else if (start) begin
      ist_r <= I_RECV;
      bcnt_r <= 4'h0;
      addr_ph_r <= 1'b1;
      ctrl_ph_r <= 1'b1;
    end else if (stop) begin
      ist_r <= I_IDLE;
    end else begin
      unique case (ist_r)
        I_IDLE, I_SKIP: begin
        end
        I_RECV: begin
          if (scl_rise) begin
            ishift_r <= {ishift_r[6:0], sda};
            bcnt_r <= bcnt_r + 4'h1;
          end else if (byte_end) begin
            addr_ph_r <= 1'b0;
            if (addr_ph_r) begin
              ist_r <= match ? I_ACK : I_SKIP;
            end else begin
              ist_r <= I_ACK;
              if (ctrl_ph_r) begin
                ctrl_ph_r <= 1'b0;
                co_r <= ishift_r[CTRL_CO];
                a0_r <= ishift_r[CTRL_A0];
              end else begin
                ctrl_ph_r <= co_r;
              end
            end
          end
        end
        I_ACK: begin
          if (scl_fall) begin
            ist_r <= I_RECV;
            bcnt_r <= 4'h0;
          end
        end
        default: ist_r <= I_IDLE;
      endcase
    end
  end

  // Acknowledge spans the eighth falling edge to the ninth
  assign db_oe = rd_oe ? (data_length_bit ? 8'hFF : 8'hF0) :
    {1'b0, ist_r == I_ACK, 6'h00};
  assign db_out = dout_r;

  // ----------------------------------------------------------------
  // Byte steering and execution
  // ----------------------------------------------------------------
  logic byte_v_r, byte_rs_r, init_r;
  logic [7:0] byte_d_r;
  logic [6:0] iaddr_r, ac_step;
  logic [BW-1:0] busy_cnt_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      byte_v_r <= 1'b0;
      byte_d_r <= 8'h00;
      byte_rs_r <= 1'b0;
    end else begin
      byte_v_r <= par_ev || spi_ev || i2c_ev;
      if (par_ev) begin
        byte_d_r <= data_length_bit ? db_s2_r : {hi_r, db_s2_r[7:4]};
        byte_rs_r <= rs_s2_r;
      end else if (spi_ev) begin
        byte_d_r <= sbyte_r;
        byte_rs_r <= srs_r;
      end else if (i2c_ev) begin
        byte_d_r <= ishift_r;
        byte_rs_r <= a0_r;
      end
    end
  end

  assign ac_step = addr_increment ? address_counter + 7'h01 : address_counter - 7'h01;
  assign busy_indication = init_r || (busy_cnt_r != '0);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      init_r <= 1'b1;
      iaddr_r <= 7'h00;
      busy_cnt_r <= '0;
      address_counter <= 7'h00;
      data_length_bit <= 1'b1;
      two_line <= 1'b0;
      font_tall <= 1'b0;
      display_on <= 1'b0;
      cursor_on <= 1'b0;
      blink_on <= 1'b0;
      addr_increment <= 1'b1;
      display_shift <= 1'b0;
      instr_valid <= 1'b0;
      instruction_holding_reg <= 8'h00;
      data_holding_reg <= 8'h00;
      ram_we <= 1'b0;
      ram_addr <= 7'h00;
      ram_wdata <= 8'h00;
    end else begin
      instr_valid <= 1'b0;
      ram_we <= 1'b0;
      ram_addr <= address_counter;
      if (init_r) begin
        ram_we <= 1'b1;
        ram_addr <= iaddr_r;
        ram_wdata <= SPACE_CODE;
        iaddr_r <= iaddr_r + 7'h01;
        if (iaddr_r == 7'(RAM_DEPTH - 1)) init_r <= 1'b0;
      end else if (byte_v_r) begin
        busy_cnt_r <= BW'(BUSY_CYC);
        if (byte_rs_r) begin
          data_holding_reg <= byte_d_r;
          ram_we <= 1'b1;
          ram_wdata <= byte_d_r;
          address_counter <= ac_step;
        end else begin
          instruction_holding_reg <= byte_d_r;
          instr_valid <= 1'b1;
          casez (byte_d_r)
            8'b1???????: address_counter <= byte_d_r[6:0];
            8'b01??????: address_counter <= {1'b0, byte_d_r[5:0]};
            8'b001?????: begin
              data_length_bit <= byte_d_r[FS_DL];
              two_line <= byte_d_r[FS_N];
              font_tall <= byte_d_r[FS_F];
            end
            8'b0001????: begin
              if (!byte_d_r[SH_SC]) begin
                address_counter <= byte_d_r[SH_RL] ? address_counter + 7'h01 :
                  address_counter - 7'h01;
              end
            end
            8'b00001???: begin
              display_on <= byte_d_r[DC_D];
              cursor_on <= byte_d_r[DC_C];
              blink_on <= byte_d_r[DC_B];
            end
            8'b000001??: begin
              addr_increment <= byte_d_r[EM_ID];
              display_shift <= byte_d_r[EM_S];
            end
            8'b0000001?: address_counter <= 7'h00;
            8'b00000001: begin
              address_counter <= 7'h00;
              addr_increment <= 1'b1;
            end
            default: begin
            end
          endcase
        end
      end else begin
        if (busy_cnt_r != '0) busy_cnt_r <= busy_cnt_r - BW'(1);
        if (rd_done && rs_s2_r) address_counter <= ac_step;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_init_busy;
    init_r |-> busy_indication ##1
      (ram_we && ram_wdata == SPACE_CODE && ram_addr == $past(iaddr_r));
  endproperty
  a_init_busy: assert property (p_init_busy) else $error("busy low during init");

  property p_first_nib;
    par_wr && !data_length_bit && !nib_r && !busy_indication |=> ##1 !busy_indication;
  endproperty
  a_first_nib: assert property (p_first_nib) else $error("busy after first nibble");

  property p_second_nib;
    par_wr && !data_length_bit && nib_r && !init_r |-> ##2 busy_indication;
  endproperty
  a_second_nib: assert property (p_second_nib) else $error("no busy after byte");

  property p_byte_wide;
    par_wr && data_length_bit |=> byte_v_r && byte_d_r == $past(db_s2_r);
  endproperty
  a_byte_wide: assert property (p_byte_wide) else $error("byte-wide capture wrong");

  property p_ack;
    ist_r == I_ACK && scl |-> db_oe[PIN_SDA] && !db_out[PIN_SDA];
  endproperty
  a_ack: assert property (p_ack) else $error("SDA not held low for ack");

  property p_nomatch;
    byte_end && addr_ph_r && !match && !start && !stop |=> ist_r == I_SKIP && !db_oe[PIN_SDA];
  endproperty
  a_nomatch: assert property (p_nomatch) else $error("mismatch not ignored");

  property p_start_stop;
    (start |=> ist_r == I_RECV && bcnt_r == 4'h0) and (stop && !start |=> ist_r == I_IDLE);
  endproperty
  a_start_stop: assert property (p_start_stop) else $error("start or stop missed");

  property p_ram_step;
    byte_v_r && byte_rs_r && !init_r |=>
      address_counter == $past(ac_step) && ram_we && ram_addr == $past(address_counter);
  endproperty
  a_ram_step: assert property (p_ram_step) else $error("RAM write or step wrong");

  property p_i2c_sel;
    i2c_ev |=> byte_rs_r == $past(a0_r) ##1 (byte_rs_r ? !instr_valid : instr_valid || init_r);
  endproperty
  a_i2c_sel: assert property (p_i2c_sel) else $error("data-select steering wrong");
endmodule
`default_nettype wire

// *** dv/host_model.sv ***
// Host processor model driving the parallel, SPI and I2C links
`timescale 1ns/1ns
`default_nettype none
module host_model (
  // Clock
  input wire logic core_clk,
  // Host pins
  output logic enable_strobe,
  output logic register_select,
  output logic read_not_write,
  output logic serial_clk,
  output logic [7:0] db_in,
  // Device pins
  input wire logic [7:0] db_out,
  input wire logic [7:0] db_oe
);
  logic [7:0] drv = 8'hFF;
  logic nib_mode = 1'b0;
  // SDA has a pull-up, so the device can only pull it low
  assign db_in = {drv[7], drv[6] & ~(db_oe[6] & ~db_out[6]), drv[5:0]};
  initial begin
    enable_strobe = 1'b0;
    register_select = 1'b0;
    read_not_write = 1'b0;
    serial_clk = 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // --------------------------------
  // Parallel bus
  // --------------------------------
  task automatic strobe(input logic rs, input logic rd, input logic [7:0] d,
                        output logic [7:0] q);
    register_select = rs;
    read_not_write = rd;
    // Released lines must not keep the last value
    drv = rd ? ~drv : d;
    cyc(1);
    enable_strobe = 1'b1;
    cyc(5);
    q = db_out;
    enable_strobe = 1'b0;
    cyc(4);
  endtask
  task automatic poll(output logic [7:0] q);
    logic [7:0] lo;
    for (int i = 0; i < 200; i++) begin
      strobe(1'b0, 1'b1, 8'h00, q);
      if (nib_mode) begin
        strobe(1'b0, 1'b1, 8'h00, lo);
        q = {q[7:4], lo[7:4]};
      end
      if (q[7] === 1'b0) break;
    end
    cyc(1);
  endtask
  task automatic write(input logic rs, input logic [7:0] d);
    logic [7:0] q;
    logic fs;
    fs = !rs && d[7:5] == 3'b001;
    if (nib_mode) strobe(rs, 1'b0, {d[7:4], ~d[3:0]}, q);
    strobe(rs, 1'b0, nib_mode ? {d[3:0], ~d[7:4]} : d, q);
    if (fs) nib_mode = ~d[4];
    poll(q);
  endtask
  // --------------------------------
  // Serial links
  // --------------------------------
  task automatic spi_pulse;
    repeat (4) begin
      #62 serial_clk = 1'b0;
      #63 serial_clk = 1'b1;
    end
  endtask
  task automatic spi_byte(input logic rs, input logic [7:0] d);
    drv[5] = 1'b0;
    register_select = rs;
    for (int i = 7; i >= 0; i--) begin
      #62 serial_clk = 1'b0;
      drv[7] = d[i];
      #63 serial_clk = 1'b1;
    end
    #62 drv[7] = ~d[0];
  endtask
  task automatic spi_end;
    drv[5] = 1'b1;
    spi_pulse();
  endtask
  task automatic i2c_setup(input logic [1:0] sa);
    drv = {6'b110000, sa};
  endtask
  task automatic i2c_start;
    cyc(4);
    drv[6] = 1'b0;
    cyc(4);
    drv[7] = 1'b0;
  endtask
  task automatic i2c_stop;
    drv[6] = 1'b0;
    cyc(3);
    drv[7] = 1'b1;
    cyc(4);
    drv[6] = 1'b1;
    cyc(4);
  endtask
  task automatic i2c_bit(input logic b, output logic s);
    drv[6] = b;
    cyc(3);
    drv[7] = 1'b1;
    cyc(1);
    s = db_in[6];
    cyc(2);
    s = s | db_in[6];
    cyc(1);
    drv[7] = 1'b0;
  endtask
  task automatic i2c_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) i2c_bit(d[i], s);
    i2c_bit(1'b1, s);
    ack = ~s;
  endtask
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking testbench for the character display host interface
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import char_lcd_pkg::*;
  localparam int BUSY = 12;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hi = 1'b0;
  logic lo = 1'b0;
  logic enable_strobe, register_select, read_not_write, serial_clk;
  logic [7:0] db_in, db_out, db_oe, ram_wdata, ram_rdata, ir, dr, set_v, q;
  logic [6:0] ram_addr, ac, ac_exp;
  logic ram_we, instr_valid, busy, inc_exp;
  logic [7:0] mem [0:127];
  logic [14:0] wq[$];
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  int seed = 8;
  int ivc = 0;
  assign ram_rdata = mem[ram_addr];
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  char_lcd_host_interface #(.BUSY_CYC(BUSY)) char_lcd_host_interface_inst (
    .core_clk(core_clk), .rst_n(rst_n), .serial_clk(serial_clk),
    .link_select_strap_hi(hi), .link_select_strap_lo(lo),
    .enable_strobe(enable_strobe), .register_select(register_select),
    .read_not_write(read_not_write), .db_in(db_in), .db_out(db_out), .db_oe(db_oe),
    .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
    .instr_valid(instr_valid), .instruction_holding_reg(ir), .data_holding_reg(dr),
    .data_length_bit(set_v[7]), .two_line(set_v[6]), .font_tall(set_v[5]),
    .display_on(set_v[4]), .cursor_on(set_v[3]), .blink_on(set_v[2]),
    .addr_increment(set_v[1]), .display_shift(set_v[0]),
    .busy_indication(busy), .address_counter(ac));
  host_model host_model_inst (
    .core_clk(core_clk), .enable_strobe(enable_strobe),
    .register_select(register_select), .read_not_write(read_not_write),
    .serial_clk(serial_clk), .db_in(db_in), .db_out(db_out), .db_oe(db_oe));
  always @(posedge core_clk) begin
    if (ram_we === 1'b1) begin
      mem[ram_addr] <= ram_wdata;
      wq.push_back({ram_addr, ram_wdata});
    end
    if (instr_valid === 1'b1) ivc++;
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end
  task automatic conclude;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [6:0] step(input logic [6:0] a, input logic inc);
    return inc ? a + 7'h01 : a - 7'h01;
  endfunction
  task automatic expect_w(input logic [7:0] d);
    logic [14:0] e;
    e = (wq.size() > 0) ? wq.pop_front() : 15'h7FFF;
    check("ram write", {1'b0, e}, {1'b0, ac_exp, d});
    ac_exp = step(ac_exp, inc_exp);
  endtask
  task automatic do_reset(input logic h, input logic l);
    hi = h;
    lo = l;
    rst_n = 1'b0;
    host_model_inst.nib_mode = 1'b0;
    fork
      host_model_inst.spi_pulse();
      repeat (5) @(negedge core_clk);
    join
    // Serial pulses end on a rising core edge; move off it
    @(negedge core_clk);
    check("busy in reset", busy, 1'b1);
    check("settings", set_v, 8'h82);
    wq.delete();
    rst_n = 1'b1;
    // Serial-side reset only lets go after clock edges
    if (h && !l) host_model_inst.spi_end();
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge core_clk);
    // Last fill write is logged one edge after busy drops
    @(negedge core_clk);
    check("fill count", wq.size(), 80);
    foreach (wq[i]) check("fill", wq[i], {i[6:0], SPACE_CODE});
    wq.delete();
    inc_exp = 1'b1;
  endtask
  task automatic i2c_send(input logic [7:0] b, input logic exp);
    logic ack;
    host_model_inst.i2c_byte(b, ack);
    check("i2c ack", ack, exp);
  endtask
  initial begin
    logic [7:0] d;
    logic [1:0] sa;
    // --------------------------------
    // Parallel bus, byte-wide then nibble
    // --------------------------------
    do_reset(1'b0, 1'b0);
    host_model_inst.write(1'b0, 8'h90);
    ac_exp = 7'h10;
    check("ir", ir, 8'h90);
    repeat (4) begin
      d = 8'($random(seed));
      host_model_inst.write(1'b1, d);
      expect_w(d);
      check("dr", dr, d);
    end
    check("ac", ac, ac_exp);
    host_model_inst.write(1'b0, 8'h04);
    inc_exp = 1'b0;
    host_model_inst.strobe(1'b1, 1'b0, 8'h5A, q);
    host_model_inst.strobe(1'b0, 1'b1, 8'h00, q);
    check("busy read", q, {1'b1, step(ac_exp, 1'b0)});
    expect_w(8'h5A);
    host_model_inst.poll(q);
    check("idle read", q, {1'b0, ac_exp});
    host_model_inst.write(1'b0, 8'h94);
    host_model_inst.strobe(1'b1, 1'b1, 8'h00, q);
    check("ram read", q, 8'h5A);
    host_model_inst.write(1'b0, 8'h20);
    check("length bit", set_v[7], 1'b0);
    d = 8'($random(seed));
    host_model_inst.strobe(1'b1, 1'b0, {d[7:4], ~d[3:0]}, q);
    host_model_inst.cyc(6);
    check("busy first nibble", busy, 1'b0);
    host_model_inst.strobe(1'b1, 1'b0, {d[3:0], ~d[7:4]}, q);
    host_model_inst.cyc(3);
    check("busy second nibble", busy, 1'b1);
    host_model_inst.poll(q);
    expect_w(d);
    check("nibble read", q, {1'b0, ac_exp});
    host_model_inst.write(1'b0, 8'h30);
    check("length bit", set_v[7], 1'b1);
    $display("test parallel done");
    // --------------------------------
    // SPI
    // --------------------------------
    do_reset(1'b1, 1'b0);
    host_model_inst.spi_byte(1'b0, 8'h88);
    host_model_inst.cyc(BUSY + 20);
    ac_exp = 7'h08;
    check("spi ir", ir, 8'h88);
    d = 8'($random(seed));
    host_model_inst.spi_byte(1'b1, d);
    host_model_inst.spi_byte(1'b1, ~d);
    host_model_inst.spi_end();
    host_model_inst.cyc(BUSY + 20);
    expect_w(d);
    expect_w(~d);
    $display("test spi done");
    // --------------------------------
    // I2C
    // --------------------------------
    sa = 2'($random(seed));
    host_model_inst.i2c_setup(sa);
    do_reset(1'b0, 1'b1);
    host_model_inst.i2c_start();
    i2c_send({5'h0F, sa, 1'b0}, 1'b1);
    i2c_send(8'h80, 1'b1);
    i2c_send(8'h30, 1'b1);
    i2c_send(8'h80, 1'b1);
    i2c_send(8'h8A, 1'b1);
    i2c_send(8'h55, 1'b1);
    d = 8'($random(seed));
    i2c_send(d, 1'b1);
    i2c_send(~d, 1'b1);
    host_model_inst.i2c_stop();
    ac_exp = 7'h0A;
    check("i2c ir", ir, 8'h8A);
    expect_w(d);
    expect_w(~d);
    host_model_inst.i2c_start();
    i2c_send({5'h0F, ~sa, 1'b0}, 1'b0);
    i2c_send(8'h40, 1'b0);
    i2c_send(8'hAA, 1'b0);
    host_model_inst.i2c_stop();
    check("ignored writes", wq.size(), 0);
    ivc = 0;
    host_model_inst.i2c_start();
    i2c_send({5'h0F, sa, 1'b0}, 1'b1);
    i2c_send(8'h00, 1'b1);
    i2c_send(8'h0C, 1'b1);
    i2c_send(8'h06, 1'b1);
    host_model_inst.i2c_stop();
    check("display on", set_v[4], 1'b1);
    check("i2c ir last", ir, 8'h06);
    check("instr count", ivc, 2);
    check("i2c settings", set_v, 8'h92);
    $display("test i2c done");
    conclude();
  end
endmodule
`default_nettype wire
